// ==== shared/sbdp_pkg.sv ====
// Constants and types for the buffered SPI data path.
// Assumes a byte-wide register port with an 8-bit address.
package sbdp_pkg;
	localparam int         ADDR_W     = 8;
	localparam int         DATA_W     = 8;
	// Register offsets
	localparam logic [7:0] A_TXB      = 8'h29;
	localparam logic [7:0] A_RXB      = 8'h2A;
	localparam logic [7:0] A_CSR      = 8'h2B;
	localparam logic [7:0] A_CFG      = 8'h2C;
	localparam logic [7:0] A_IST      = 8'h2D;
	localparam logic [7:0] A_IMSK     = 8'h2E;
	// Control and status fields
	localparam int         CSR_EN     = 0;
	localparam int         CSR_CPOL   = 1;
	localparam int         CSR_CPHA   = 2;
	localparam int         CSR_RXF    = 3;
	localparam int         CSR_TXE    = 4;
	localparam int         CSR_CMPL   = 5;
	localparam int         CSR_OVR    = 6;
	localparam int         CSR_LSB    = 7;
	localparam logic [7:0] CSR_RESET  = 8'h00;
	localparam logic [7:0] CSR_WMASK  = 8'h87;
	// Configuration fields
	localparam int         CFG_SLAVE  = 0;
	localparam int         CFG_SEL_LO = 5;
	localparam int         SEL_W      = 3;
	localparam logic [7:0] CFG_RESET  = 8'h00;
	// Interrupt status fields
	localparam int         IST_W      = 4;
	localparam int         IST_TXE    = 0;
	localparam int         IST_CMPL   = 1;
	localparam int         IST_RXF    = 2;
	localparam int         IST_OVR    = 3;
	localparam logic [3:0] IST_RESET  = 4'h0;
	// Frame counts
	localparam logic [3:0] BIT_LAST   = 4'h7;
	localparam logic [4:0] TOG_LAST   = 5'h0F;
	localparam logic [4:0] TOG_TOTAL  = 5'h10;
	// Pin sync order: ss_n, miso, mosi, sclk
	localparam logic [3:0] PIN_RESET  = 4'h8;

	typedef enum logic {
		ST_IDLE  = 1'b0,
		ST_SHIFT = 1'b1
	} sbdp_state_t;
endpackage

// ==== src/sbdp_sync.sv ====
// Two-stage synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to i_clk.
`timescale 1ns/10ps
`default_nettype none
module sbdp_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_d,
	output var  logic [W-1:0] o_q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_q <= RST_VAL;
			o_q    <= RST_VAL;
		end else begin
			meta_q <= i_d;
			o_q    <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ==== src/sbdp_div.sv ====
// Half-period tick generator for the master serial clock.
// Assumes i_sel is stable while i_run is high.
`timescale 1ns/10ps
`default_nettype none
module sbdp_div #(
	parameter int SEL_W = 3
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_run,
	input  wire logic [SEL_W-1:0] i_sel,
	output var  logic             o_tick
);
	localparam int CNT_W = (1 << SEL_W) - 1;

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] lim;

	// Half period is 2^sel system clocks
	assign lim    = {CNT_W{1'b1}} >> (CNT_W - int'(i_sel));
	assign o_tick = i_run && (cnt_q == lim);

	always_ff @(posedge i_clk) begin
		if (i_rst || !i_run || o_tick) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end
endmodule
`default_nettype wire

// ==== src/sbdp_top.sv ====
// Buffered SPI data path: transmit buffer, shifter, receive buffer, control/status.
// Assumes a single-cycle register port and an SPI partner on the pins.
`timescale 1ns/10ps
`default_nettype none
module sbdp_top
	import sbdp_pkg::*;
(
	input  wire logic                        I_CLK,
	input  wire logic                        I_RST,
	input  wire logic [sbdp_pkg::ADDR_W-1:0] I_ADDR,
	input  wire logic [sbdp_pkg::DATA_W-1:0] I_WDATA,
	input  wire logic                        I_WR,
	input  wire logic                        I_RD,
	output var  logic [sbdp_pkg::DATA_W-1:0] O_RDATA,
	output var  logic                        O_IRQ,
	input  wire logic                        I_SCLK,
	output var  logic                        O_SCLK,
	output var  logic                        O_SCLK_OE,
	input  wire logic                        I_MOSI,
	output var  logic                        O_MOSI,
	output var  logic                        O_MOSI_OE,
	input  wire logic                        I_MISO,
	output var  logic                        O_MISO,
	output var  logic                        O_MISO_OE,
	input  wire logic                        I_SS_N
);
	import sbdp_pkg::*;

	logic [DATA_W-1:0] ctl_q;
	logic [DATA_W-1:0] cfg_q;
	logic [DATA_W-1:0] txb_q;
	logic [DATA_W-1:0] rxb_q;
	logic              tx_full_q;
	logic              txe_q;
	logic              rxf_q;
	logic              cmpl_q;
	logic              ovr_q;
	logic [IST_W-1:0]  ist_q;
	logic [IST_W-1:0]  imsk_q;
	logic [IST_W-1:0]  ev;
	logic [3:0]        pin_s;
	logic              sclk_s;
	logic              mosi_s;
	logic              miso_s;
	logic              ss_n_s;
	logic              sclk_prev_q;
	sbdp_state_t       state_q;
	logic [4:0]        tog_q;
	logic              sclk_q;
	logic              tick;
	logic              s_active_q;
	logic [3:0]        samp_cnt_q;
	logic [DATA_W-1:0] tx_sh_q;
	logic [DATA_W-1:0] tx_sh_d;
	logic [DATA_W-1:0] rx_sh_q;
	logic [DATA_W-1:0] rx_sh_d;
	logic              tx_bit_d;
	logic              in_bit;
	logic              wr_txb;
	logic              wr_rxb;
	logic              wr_csr;
	logic              wr_cfg;
	logic              wr_ist;
	logic              wr_imsk;
	logic              rd_rxb;
	logic              rd_csr;
	logic              en;
	logic              slave;
	logic              cpol;
	logic              cpha;
	logic              lsb;
	logic              master_on;
	logic              slave_on;
	logic              eng_on;
	logic              mst_load;
	logic              slv_load;
	logic              load;
	logic              m_lead;
	logic              m_trail;
	logic              s_lead;
	logic              s_trail;
	logic              samp_edge;
	logic              chg_edge;
	logic              done;
	logic              ovr_ev;
	logic [DATA_W-1:0] csr_view;

	sbdp_sync #(
		.W       (4),
		.RST_VAL (PIN_RESET)
	) u_sync (
		.i_clk (I_CLK),
		.i_rst (I_RST),
		.i_d   ({I_SS_N, I_MISO, I_MOSI, I_SCLK}),
		.o_q   (pin_s)
	);

	assign {ss_n_s, miso_s, mosi_s, sclk_s} = pin_s;

	// Register decode
	assign wr_txb  = I_WR && (I_ADDR == A_TXB);
	assign wr_rxb  = I_WR && (I_ADDR == A_RXB);
	assign wr_csr  = I_WR && (I_ADDR == A_CSR);
	assign wr_cfg  = I_WR && (I_ADDR == A_CFG);
	assign wr_ist  = I_WR && (I_ADDR == A_IST);
	assign wr_imsk = I_WR && (I_ADDR == A_IMSK);
	assign rd_rxb  = I_RD && (I_ADDR == A_RXB);
	assign rd_csr  = I_RD && (I_ADDR == A_CSR);

	assign en        = ctl_q[CSR_EN];
	assign cpol      = ctl_q[CSR_CPOL];
	assign cpha      = ctl_q[CSR_CPHA];
	assign lsb       = ctl_q[CSR_LSB];
	assign slave     = cfg_q[CFG_SLAVE];
	assign master_on = en && !slave;
	assign slave_on  = en && slave && !ss_n_s;
	assign eng_on    = master_on || slave_on;

	// Master bit clock
	sbdp_div #(
		.SEL_W (SEL_W)
	) u_div (
		.i_clk  (I_CLK),
		.i_rst  (I_RST),
		.i_run  (master_on && (state_q == ST_SHIFT)),
		.i_sel  (cfg_q[CFG_SEL_LO +: SEL_W]),
		.o_tick (tick)
	);

	assign mst_load = master_on && (state_q == ST_IDLE) && tx_full_q;
	assign slv_load = en && slave && !s_active_q && tx_full_q;
	assign load     = mst_load || slv_load;

	always_ff @(posedge I_CLK) begin
		if (I_RST || !master_on) begin
			state_q <= ST_IDLE;
			tog_q   <= 5'h00;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (mst_load) begin
						state_q <= ST_SHIFT;
						tog_q   <= 5'h00;
					end
				end
				ST_SHIFT: begin
					if (tick) begin
						tog_q <= tog_q + 5'h01;
						if (tog_q == TOG_LAST) begin
							state_q <= ST_IDLE;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			sclk_q <= CSR_RESET[CSR_CPOL];
		end else if (!master_on || (state_q != ST_SHIFT)) begin
			sclk_q <= cpol;
		end else if (tick) begin
			sclk_q <= ~sclk_q;
		end
	end

	// Leading edge leaves the idle level, trailing edge returns to it
	assign m_lead  = master_on && (state_q == ST_SHIFT) && tick && (sclk_q == cpol);
	assign m_trail = master_on && (state_q == ST_SHIFT) && tick && (sclk_q != cpol);
	assign s_lead  = slave_on && (sclk_prev_q == cpol) && (sclk_s != cpol);
	assign s_trail = slave_on && (sclk_prev_q != cpol) && (sclk_s == cpol);

	// Phase set: change on leading, sample on trailing
	assign samp_edge = cpha ? (m_trail || s_trail) : (m_lead || s_lead);
	assign chg_edge  = cpha ? (m_lead || s_lead) : (m_trail || s_trail);
	assign done      = samp_edge && (samp_cnt_q == BIT_LAST);
	assign in_bit    = slave ? mosi_s : miso_s;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			sclk_prev_q <= PIN_RESET[0];
		end else begin
			sclk_prev_q <= sclk_s;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST || !slave_on || done) begin
			s_active_q <= 1'b0;
		end else if (s_lead || s_trail) begin
			s_active_q <= 1'b1;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST || !eng_on || done || load) begin
			samp_cnt_q <= 4'h0;
		end else if (samp_edge) begin
			samp_cnt_q <= samp_cnt_q + 4'h1;
		end
	end

	// Shifters, both directions together
	always_comb begin
		rx_sh_d = lsb ? {in_bit, rx_sh_q[DATA_W-1:1]} : {rx_sh_q[DATA_W-2:0], in_bit};
		if (load) begin
			tx_sh_d = txb_q;
		end else if (chg_edge && (samp_cnt_q != 4'h0)) begin
			tx_sh_d = lsb ? {1'b0, tx_sh_q[DATA_W-1:1]} : {tx_sh_q[DATA_W-2:0], 1'b0};
		end else begin
			tx_sh_d = tx_sh_q;
		end
		tx_bit_d = lsb ? tx_sh_d[0] : tx_sh_d[DATA_W-1];
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			tx_sh_q <= '0;
			rx_sh_q <= '0;
		end else begin
			tx_sh_q <= tx_sh_d;
			if (samp_edge) begin
				rx_sh_q <= rx_sh_d;
			end
		end
	end

	// Pin drivers
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_MOSI    <= 1'b1;
			O_MISO    <= 1'b1;
			O_MOSI_OE <= 1'b0;
			O_MISO_OE <= 1'b0;
			O_SCLK_OE <= 1'b0;
		end else begin
			O_MOSI    <= tx_bit_d;
			O_MISO    <= ss_n_s ? 1'b1 : tx_bit_d;
			O_MOSI_OE <= master_on;
			O_MISO_OE <= en && slave;
			O_SCLK_OE <= master_on;
		end
	end

	assign O_SCLK = sclk_q;

	// Transmit buffer and its flags
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			txb_q     <= '0;
			tx_full_q <= 1'b0;
		end else if (wr_txb) begin
			txb_q     <= I_WDATA;
			tx_full_q <= 1'b1;
		end else if (load) begin
			tx_full_q <= 1'b0;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			txe_q <= CSR_RESET[CSR_TXE];
		end else if (load) begin
			txe_q <= 1'b1;
		end else if (wr_txb) begin
			txe_q <= 1'b0;
		end else if (en && !tx_full_q) begin
			txe_q <= 1'b1;
		end
	end

	// Receive buffer and its flags; set wins over clear
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			rxb_q <= '0;
		end else if (done) begin
			rxb_q <= rx_sh_d;
		end
	end

	assign ovr_ev = done && rxf_q && !(rd_rxb || wr_rxb);

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			rxf_q  <= CSR_RESET[CSR_RXF];
			cmpl_q <= CSR_RESET[CSR_CMPL];
			ovr_q  <= CSR_RESET[CSR_OVR];
		end else begin
			if (done) begin
				rxf_q <= 1'b1;
			end else if (rd_rxb || wr_rxb) begin
				rxf_q <= 1'b0;
			end
			if (done) begin
				cmpl_q <= 1'b1;
			end else if (rd_csr) begin
				cmpl_q <= 1'b0;
			end
			if (ovr_ev) begin
				ovr_q <= 1'b1;
			end else if (rd_csr) begin
				ovr_q <= 1'b0;
			end
		end
	end

	// Writable control and configuration bits
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			ctl_q <= CSR_RESET;
			cfg_q <= CFG_RESET;
		end else begin
			if (wr_csr) begin
				ctl_q <= I_WDATA & CSR_WMASK;
			end
			if (wr_cfg) begin
				cfg_q <= I_WDATA;
			end
		end
	end

	// Interrupt status, mask and output
	assign ev[IST_TXE]  = load;
	assign ev[IST_CMPL] = done;
	assign ev[IST_RXF]  = done;
	assign ev[IST_OVR]  = ovr_ev;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			ist_q  <= IST_RESET;
			imsk_q <= IST_RESET;
			O_IRQ  <= 1'b0;
		end else begin
			ist_q <= (ist_q & ~(wr_ist ? I_WDATA[IST_W-1:0] : IST_RESET)) | ev;
			if (wr_imsk) begin
				imsk_q <= I_WDATA[IST_W-1:0];
			end
			O_IRQ <= |(ist_q & imsk_q);
		end
	end

	// Read port
	assign csr_view = {ctl_q[CSR_LSB], ovr_q, cmpl_q, txe_q, rxf_q, ctl_q[CSR_CPHA:CSR_EN]};

	always_ff @(posedge I_CLK) begin
		if (I_RST || !I_RD) begin
			O_RDATA <= '0;
		end else begin
			case (I_ADDR)
				A_RXB:   O_RDATA <= rxb_q;
				A_CSR:   O_RDATA <= csr_view;
				A_CFG:   O_RDATA <= cfg_q;
				A_IST:   O_RDATA <= {{(DATA_W-IST_W){1'b0}}, ist_q};
				A_IMSK:  O_RDATA <= {{(DATA_W-IST_W){1'b0}}, imsk_q};
				default: O_RDATA <= '0;
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);

	logic       sclk_h_q;
	logic [4:0] hcnt_q;

	always_ff @(posedge I_CLK) begin
		if (I_RST || load) begin
			hcnt_q <= 5'h00;
		end else begin
			hcnt_q <= hcnt_q + {4'h0, sclk_q ^ sclk_h_q};
		end
		sclk_h_q <= sclk_q;
	end

	a_master_load_start: assert property (
		mst_load && !wr_txb |=> (state_q == ST_SHIFT) && (tx_sh_q == $past(txb_q)) && txe_q)
		else $error("master did not load and start");
	a_queue_holds: assert property (
		master_on && (state_q == ST_SHIFT) && wr_txb && !chg_edge |=> $stable(tx_sh_q) && tx_full_q)
		else $error("queued byte disturbed shifter");
	a_txe_clear: assert property (
		wr_txb && !load |=> !txe_q ##1 (txe_q == $past(load)))
		else $error("tx empty not cleared by write");
	a_rx_capture: assert property (
		done |=> rxf_q && cmpl_q && (rxb_q == $past(rx_sh_d)))
		else $error("finished byte not captured");
	a_rx_clear: assert property (
		(rd_rxb || wr_rxb) && !done |=> !rxf_q && $stable(rxb_q))
		else $error("rx full not cleared or buffer written");
	a_cmpl_read: assert property (
		rd_csr && !done |=> !cmpl_q && (O_RDATA[CSR_CMPL] == $past(cmpl_q)))
		else $error("complete flag read handling wrong");
	a_overrun_set: assert property (
		done && rxf_q && !rd_rxb && !wr_rxb |=> ovr_q)
		else $error("overrun not flagged");
	a_sclk_idle: assert property (
		master_on && (state_q == ST_IDLE) && $past(state_q == ST_IDLE) && $stable(ctl_q) |-> sclk_q == cpol)
		else $error("serial clock not at idle level");
	a_eight_pulses: assert property (
		$past(state_q == ST_SHIFT) && (state_q == ST_IDLE) && $past(master_on) && master_on
		|-> (hcnt_q + {4'h0, sclk_q ^ sclk_h_q}) == TOG_TOTAL)
		else $error("transfer was not eight pulses");
	a_read_window: assert property (
		!I_RD |=> O_RDATA == '0)
		else $error("read data outside its cycle");
endmodule
`default_nettype wire

// ==== bench/sbdp_slave_model.sv ====
// SPI slave model facing the master pins, mode 0 only.
// Assumes the bench arms a reply byte while the link is idle.
`timescale 1ns/10ps
`default_nettype none
module sbdp_slave_model (
	input  wire logic       i_sclk,
	input  wire logic       i_mosi,
	input  wire logic       i_lsb,
	input  wire logic       i_arm,
	input  wire logic [7:0] i_tx,
	output var  logic       o_miso,
	output var  logic [7:0] o_rx
);
	logic [7:0] sh;
	int         cnt;
	initial begin
		sh = 8'h00;
		cnt = 0;
		o_rx = 8'h00;
	end
	assign o_miso = i_lsb ? sh[0] : sh[7];
	always @(posedge i_arm) begin
		sh = i_tx;
		cnt = 0;
	end
	// Sample on the leading edge
	always @(posedge i_sclk) begin
		o_rx = i_lsb ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
		cnt = cnt + 1;
	end
	// Shift on the trailing edge; the vacated bit toggles so stale data never looks valid
	always @(negedge i_sclk) begin
		if (cnt == 8) begin
			sh = i_tx;
			cnt = 0;
		end else begin
			sh = i_lsb ? {~sh[0], sh[7:1]} : {sh[6:0], ~sh[7]};
		end
	end
endmodule
`default_nettype wire

// ==== bench/sbdp_top_tb.sv ====
// Testbench for the buffered SPI data path, master and slave modes.
// Assumes the slave model on the master pins and the bench as remote master.
`timescale 1ns/10ps
`default_nettype none
module sbdp_top_tb;
	import sbdp_pkg::*;
	logic       I_CLK = 1'b0;
	logic       I_RST = 1'b1;
	logic [7:0] I_ADDR = 8'h00;
	logic [7:0] I_WDATA = 8'h00;
	logic       I_WR = 1'b0;
	logic       I_RD = 1'b0;
	logic       I_SCLK = 1'b0;
	logic       I_MOSI = 1'b0;
	logic       I_SS_N = 1'b1;
	logic [7:0] O_RDATA;
	logic       O_IRQ;
	logic       O_SCLK;
	logic       O_MOSI;
	logic       O_MISO;
	logic       O_SCLK_OE;
	logic       O_MOSI_OE;
	logic       O_MISO_OE;
	logic       I_MISO;
	logic       model_lsb = 1'b0;
	logic       model_arm = 1'b0;
	logic [7:0] model_tx = 8'h00;
	logic [7:0] model_rx;
	logic [7:0] d;
	int         fail_count = 0;
	int         samples_checked = 0;

	always #2.5 I_CLK = ~I_CLK;

	sbdp_top i_dut (
		.I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
		.I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_IRQ(O_IRQ),
		.I_SCLK(I_SCLK), .O_SCLK(O_SCLK), .O_SCLK_OE(O_SCLK_OE),
		.I_MOSI(I_MOSI), .O_MOSI(O_MOSI), .O_MOSI_OE(O_MOSI_OE),
		.I_MISO(I_MISO), .O_MISO(O_MISO), .O_MISO_OE(O_MISO_OE), .I_SS_N(I_SS_N)
	);
	sbdp_slave_model i_model (
		.i_sclk(O_SCLK), .i_mosi(O_MOSI), .i_lsb(model_lsb), .i_arm(model_arm),
		.i_tx(model_tx), .o_miso(I_MISO), .o_rx(model_rx)
	);

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge I_CLK);
		I_ADDR <= a;
		I_WDATA <= v;
		I_WR <= 1'b1;
		@(posedge I_CLK);
		I_WR <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge I_CLK);
		I_ADDR <= a;
		I_RD <= 1'b1;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		#1 v = O_RDATA;
	endtask

	task automatic arm(input logic [7:0] v);
		model_tx = v;
		model_arm = 1'b1;
		#1 model_arm = 1'b0;
	endtask

	// Interrupt output lags status and mask by one cycle
	task automatic irq_chk(input logic exp);
		repeat (2) @(posedge I_CLK);
		#1 chk("irq", {7'h00, exp}, {7'h00, O_IRQ});
	endtask

	// Sampled off the edge; returns before the next queued byte starts clocking
	task automatic wait_irq();
		int n;
		n = 0;
		repeat (2) @(posedge I_CLK);
		#1;
		while (n < 600 && O_IRQ !== 1'b1) begin
			@(posedge I_CLK);
			#1;
			n++;
		end
		chk("irq raised", 8'h01, {7'h00, O_IRQ});
		repeat (4) @(posedge I_CLK);
	endtask

	// Remote master, clock idles low, 64 ns link period; ph picks the change edge
	task automatic slave_byte(input logic ph, input logic [7:0] m, output logic [7:0] s);
		int i;
		#7 I_SS_N <= 1'b0;
		#40;
		for (i = 7; i >= 0; i--) begin
			I_MOSI <= ph ? I_MOSI : m[i];
			#32 s[i] = ph ? s[i] : O_MISO;
			I_SCLK <= 1'b1;
			I_MOSI <= ph ? m[i] : I_MOSI;
			#32 s[i] = ph ? O_MISO : s[i];
			I_SCLK <= 1'b0;
		end
		#40 I_SS_N <= 1'b1;
	endtask

	initial begin
		#200000;
		fail_count++;
		stop_test();
	end

	initial begin
		repeat (10) @(posedge I_CLK);
		I_RST <= 1'b0;
		rd(A_CSR, d);
		chk("csr reset", CSR_RESET, d);
		chk("oe reset", 8'h00, {5'h00, O_SCLK_OE, O_MOSI_OE, O_MISO_OE});
		irq_chk(1'b0);
		wr(A_CFG, 8'h40);
		wr(A_CSR, 8'h01);
		rd(A_CSR, d);
		chk("csr enabled", 8'h11, d);
		chk("oe master", 8'h06, {5'h00, O_SCLK_OE, O_MOSI_OE, O_MISO_OE});
		rd(A_TXB, d);
		chk("tx read", 8'h00, d);
		rd(8'h30, d);
		chk("unmapped read", 8'h00, d);
		arm(8'hA5);
		wr(A_IMSK, 8'h02);
		wr(A_TXB, 8'h3C);
		repeat (2) @(posedge I_CLK);
		rd(A_CSR, d);
		chk("csr loaded", 8'h11, d);
		model_tx = 8'h5A;
		wr(A_TXB, 8'hC3);
		rd(A_CSR, d);
		chk("csr queued", 8'h01, d);
		wait_irq();
		chk("remote rx first", 8'h3C, model_rx);
		rd(A_CSR, d);
		chk("csr first done", 8'h39, d);
		rd(A_CSR, d);
		chk("csr cmpl cleared", 8'h19, d);
		wr(A_IST, 8'h0F);
		wait_irq();
		rd(A_CSR, d);
		chk("csr overrun", 8'h79, d);
		chk("remote rx second", 8'hC3, model_rx);
		rd(A_RXB, d);
		chk("rx second", 8'h5A, d);
		rd(A_CSR, d);
		chk("csr rx read", 8'h11, d);
		wr(A_IMSK, 8'h00);
		irq_chk(1'b0);
		wr(A_IMSK, 8'h02);
		irq_chk(1'b1);
		wr(A_IST, 8'h0F);
		irq_chk(1'b0);
		wr(A_CSR, 8'h81);
		model_lsb = 1'b1;
		arm(8'h01);
		wr(A_TXB, 8'h80);
		wait_irq();
		wr(A_RXB, 8'hFF);
		rd(A_CSR, d);
		chk("csr rx write", 8'hB1, d);
		rd(A_RXB, d);
		chk("rx lsb first", 8'h01, d);
		chk("remote rx lsb", 8'h80, model_rx);
		wr(A_CSR, 8'h03);
		repeat (4) @(posedge I_CLK);
		#1 chk("sclk idle high", 8'h01, {7'h00, O_SCLK});
		wr(A_CSR, 8'h00);
		wr(A_CFG, 8'h01);
		wr(A_CSR, 8'h01);
		rd(A_CSR, d);
		chk("csr slave ready", 8'h11, d);
		chk("oe slave", 8'h01, {5'h00, O_SCLK_OE, O_MOSI_OE, O_MISO_OE});
		wr(A_TXB, 8'h96);
		slave_byte(1'b0, 8'h4B, d);
		chk("slave out", 8'h96, d);
		rd(A_RXB, d);
		chk("slave rx", 8'h4B, d);
		wr(A_CSR, 8'h05);
		rd(A_CSR, d);
		chk("csr phase set", 8'h35, d);
		wr(A_TXB, 8'h69);
		slave_byte(1'b1, 8'hD2, d);
		chk("slave out phase", 8'h69, d);
		rd(A_RXB, d);
		chk("slave rx phase", 8'hD2, d);
		stop_test();
	end
endmodule
`default_nettype wire
